/* File: hdl/rmc_consts.svh */
// Constants for the remote terminal mode command handler
`ifndef RMC_CONSTS_SVH
`define RMC_CONSTS_SVH
// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define RMC_CODE_W 5
`define RMC_TBL_AW 7
`define RMC_TBL_N 128
`define RMC_CTRL_IWA_BIT 15
`define RMC_CTRL_BIWA_BIT 14
`define RMC_CTRL_SPARE_BIT 13
`define RMC_IIW_IWA_BIT 0
`define RMC_IIW_BCAST_BIT 1
`define RMC_DATA_CODE_BIT 4
// ----------------------------------------
// Mode codes of note
// ----------------------------------------
`define RMC_MC_BUS_CTRL 5'h00
`define RMC_MC_SYNC 5'h01
`define RMC_MC_TX_STATUS 5'h02
`define RMC_MC_SELF_TEST 5'h03
`define RMC_MC_TX_SHUT 5'h04
`define RMC_MC_OVR_SHUT 5'h05
`define RMC_MC_INH_FLAG 5'h06
`define RMC_MC_OVR_INH 5'h07
`define RMC_MC_RESET_RT 5'h08
`define RMC_MC_TX_VECTOR 5'h10
// ----------------------------------------
// Descriptor table layout for mode commands
// ----------------------------------------
`define RMC_DESC_BASE 16'h0200
`define RMC_DESC_SHIFT 2
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RMC_TBL_RESET 1'b0
`define RMC_WORD_RESET 16'h0000
`endif

/* File: hdl/rmc_pkg.sv */
// Types for the remote terminal mode command handler
package rmc_pkg;
	typedef enum logic [3:0] {
		RMC_RESP_NONE = 4'h1,
		RMC_RESP_STATUS = 4'h2,
		RMC_RESP_TX_DATA = 4'h4,
		RMC_RESP_RX_DATA = 4'h8
	} rmc_resp_t;
	typedef enum logic [3:0] {
		RMC_ST_IDLE = 4'h1,
		RMC_ST_LOG_INFO = 4'h2,
		RMC_ST_LOG_ADDR = 4'h4,
		RMC_ST_RAISE = 4'h8
	} rmc_state_t;
	typedef enum logic [4:0] {
		RMC_FN_OTHER = 5'h01,
		RMC_FN_BUS_CTRL = 5'h02,
		RMC_FN_TX_STATUS = 5'h04,
		RMC_FN_RESET_RT = 5'h08,
		RMC_FN_TX_VECTOR = 5'h10
	} rmc_func_t;
endpackage

/* File: hdl/rmc_mode_cmd.sv */
// Mode command decode, legality, response choice and interrupt logging
`include "rmc_consts.svh"

// Overview of operation
// - Exactly 22 code and direction pairs count as undefined mode commands.
// - Option clear at reset: undefined commands valid, judged by their table bit.
// - Valid command with table bit 0 is legal unless broadcast outside the allowed set, answered in form, status updated.
// - Table bit 1: message error set, status word only unless broadcast.
// - Option set: undefined commands ignored entirely, status left unchanged.
// - All illegal table bits are zero after reset.
// - With clear table, non-broadcast transmit codes 16 to 31 return status plus one word.
// - Dynamic bus control never accepted; acceptance status bit always zero.
// - Interrupt settings come from top two descriptor control word bits.
// - Broadcast transmit interrupts only for codes 0 to 15.
// - Access bit plus enable set pending bit and raise message interrupt.
// - Info word then address word are logged before the interrupt rises.
// - Codes 0 to 15 carry no data; answer is status word only.
// - Receive codes 16 to 31 take one data word after the command.
// - Legal transmit codes 16 to 31 answer status then exactly one word.
// - Option clear: mode data goes to indexed or ping-pong buffer, never circular.
// - Option set: mode data kept inside descriptor table entries.
// - Broadcast allowed only for transmit codes 1 and 3 to 15 and receive codes 17 to 31.
// - Transmit codes 0, 2, 8 and 16 decode to their own functions; all others to RMC_FN_OTHER.
// - In-form undefined 17, 20, 21 transmit a word; 16, 18, 19 receive one.
module rmc_mode_cmd
	import rmc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_in,
	// Options
	input wire logic undefined_codes_invalid_in,
	input wire logic simplified_mode_data_store_in,
	input wire logic interrupt_enable_in,
	// Illegalization table write port, index {bcast, tr, code}
	input wire logic tbl_wr_in,
	input wire logic [6:0] tbl_addr_in,
	input wire logic tbl_bit_in,
	// Received mode command
	input wire logic cmd_valid_in,
	input wire logic [4:0] cmd_code_in,
	input wire logic cmd_tr_in,
	input wire logic cmd_bcast_in,
	input wire logic [15:0] desc_ctrl_in,
	input wire logic [15:0] mode_data_in,
	output logic cmd_ready_out,
	// Response to the bus side
	output logic resp_valid_out,
	output rmc_resp_t resp_kind_out,
	output logic [15:0] resp_data_out,
	output rmc_func_t resp_func_out,
	output logic message_error_out,
	output logic bus_ctrl_accept_out,
	output logic store_in_descriptor_out,
	// Interrupt log and interrupt
	output logic log_wr_out,
	output logic [15:0] log_word_out,
	input wire logic irq_clear_in,
	output logic message_interrupt_out
);

	// ----------------------------------------
	// Decode functions
	// ----------------------------------------

	// True for the 22 undefined combinations
	function automatic logic is_undef(input logic tr, input logic [4:0] code);
		logic r;
		r = 1'b0;
		if (!tr && !code[`RMC_DATA_CODE_BIT]) begin
			r = 1'b1;
		end else if (!tr && (code == 5'h10 || code == 5'h12 || code == 5'h13)) begin
			r = 1'b1;
		end else if (tr && (code == 5'h11 || code == 5'h14 || code == 5'h15)) begin
			r = 1'b1;
		end
		return r;
	endfunction

	// True where broadcast may be taken
	function automatic logic bcast_ok(input logic tr, input logic [4:0] code);
		logic r;
		r = 1'b0;
		if (tr && !code[`RMC_DATA_CODE_BIT]) begin
			r = (code != `RMC_MC_BUS_CTRL) && (code != `RMC_MC_TX_STATUS);
		end else if (!tr && code[`RMC_DATA_CODE_BIT]) begin
			r = (code != `RMC_MC_TX_VECTOR);
		end
		return r;
	endfunction

	// ----------------------------------------
	// Registers and decode
	// ----------------------------------------
	logic [`RMC_TBL_N-1:0] illegal_q;
	rmc_state_t state_q;
	logic take;
	logic undef_hit;
	logic ignore;
	logic illegal;
	logic has_data;
	logic irq_want;
	logic [15:0] desc_addr_q;
	logic bcast_q;
	logic pending_q;
	rmc_func_t func_d;

	assign take = cmd_valid_in && cmd_ready_out;
	assign undef_hit = is_undef(cmd_tr_in, cmd_code_in);
	assign ignore = undef_hit && undefined_codes_invalid_in;
	// Table bit decides; broadcast outside the allowed set is illegal
	assign illegal = illegal_q[{cmd_bcast_in, cmd_tr_in, cmd_code_in}] ||
		(cmd_bcast_in && !bcast_ok(cmd_tr_in, cmd_code_in));
	assign has_data = cmd_code_in[`RMC_DATA_CODE_BIT];
	// Broadcast uses its own enable bit; broadcast transmit 16-31 never interrupts
	assign irq_want = interrupt_enable_in && !ignore &&
		(cmd_bcast_in ? (desc_ctrl_in[`RMC_CTRL_BIWA_BIT] &&
		!(cmd_tr_in && has_data)) : desc_ctrl_in[`RMC_CTRL_IWA_BIT]);
	assign cmd_ready_out = (state_q == RMC_ST_IDLE);
	assign message_interrupt_out = pending_q;

	// Function decode of transmit codes
	always_comb begin
		func_d = RMC_FN_OTHER;
		if (cmd_tr_in) begin
			case (cmd_code_in)
				`RMC_MC_BUS_CTRL: func_d = RMC_FN_BUS_CTRL;
				`RMC_MC_TX_STATUS: func_d = RMC_FN_TX_STATUS;
				`RMC_MC_RESET_RT: func_d = RMC_FN_RESET_RT;
				`RMC_MC_TX_VECTOR: func_d = RMC_FN_TX_VECTOR;
				default: func_d = RMC_FN_OTHER;
			endcase
		end
	end

	// ----------------------------------------
	// Illegalization table
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `RMC_TBL_N; gi = gi + 1) begin : g_tbl
			// One table bit, cleared by reset
			always_ff @(posedge ref_clk_in) begin
				if (reset_in) begin
					illegal_q[gi] <= `RMC_TBL_RESET;
				end else if (tbl_wr_in && tbl_addr_in == 7'(gi)) begin
					illegal_q[gi] <= tbl_bit_in;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Response
	// ----------------------------------------

	// Response pulse and kind
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			resp_valid_out <= 1'b0;
			resp_kind_out <= RMC_RESP_NONE;
			resp_func_out <= RMC_FN_OTHER;
			resp_data_out <= `RMC_WORD_RESET;
		end else begin
			resp_valid_out <= take;
			if (take) begin
				resp_func_out <= func_d;
				resp_data_out <= `RMC_WORD_RESET;
				if (ignore || (cmd_bcast_in && !cmd_tr_in && !has_data)) begin
					resp_kind_out <= RMC_RESP_NONE;
				end else if (cmd_bcast_in) begin
					resp_kind_out <= (has_data && !illegal) ? RMC_RESP_RX_DATA : RMC_RESP_NONE;
				end else if (illegal || !has_data) begin
					resp_kind_out <= RMC_RESP_STATUS;
				end else if (cmd_tr_in) begin
					resp_kind_out <= RMC_RESP_TX_DATA;
					resp_data_out <= mode_data_in;
				end else begin
					resp_kind_out <= RMC_RESP_RX_DATA;
				end
			end
		end
	end

	// Status bits: message error follows legality, ignored commands leave it
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			message_error_out <= 1'b0;
			bus_ctrl_accept_out <= 1'b0;
		end else begin
			bus_ctrl_accept_out <= 1'b0;
			if (take && !ignore) begin
				message_error_out <= illegal;
			end
		end
	end

	// Mode data storage place
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			store_in_descriptor_out <= 1'b0;
		end else if (take) begin
			store_in_descriptor_out <= simplified_mode_data_store_in;
		end
	end

	// ----------------------------------------
	// Interrupt logging
	// ----------------------------------------

	// Capture of command identity for the log
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			desc_addr_q <= `RMC_WORD_RESET;
			bcast_q <= 1'b0;
		end else if (take) begin
			desc_addr_q <= `RMC_DESC_BASE +
				(16'({cmd_tr_in, cmd_code_in}) << `RMC_DESC_SHIFT);
			bcast_q <= cmd_bcast_in;
		end
	end

	// Log sequencer
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			state_q <= RMC_ST_IDLE;
		end else begin
			case (state_q)
				RMC_ST_IDLE: state_q <= (take && irq_want) ? RMC_ST_LOG_INFO : RMC_ST_IDLE;
				RMC_ST_LOG_INFO: state_q <= RMC_ST_LOG_ADDR;
				RMC_ST_LOG_ADDR: state_q <= RMC_ST_RAISE;
				RMC_ST_RAISE: state_q <= RMC_ST_IDLE;
				default: state_q <= RMC_ST_IDLE;
			endcase
		end
	end

	// Log word output
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			log_wr_out <= 1'b0;
			log_word_out <= `RMC_WORD_RESET;
		end else begin
			log_wr_out <= 1'b0;
			if (state_q == RMC_ST_IDLE && take && irq_want) begin
				log_wr_out <= 1'b1;
				log_word_out <= 16'((16'h1 << `RMC_IIW_IWA_BIT) |
					(16'(cmd_bcast_in) << `RMC_IIW_BCAST_BIT));
			end else if (state_q == RMC_ST_LOG_INFO) begin
				log_wr_out <= 1'b1;
				log_word_out <= desc_addr_q;
			end
		end
	end

	// Pending bit; a new set wins over a clear in the same cycle
	always_ff @(posedge ref_clk_in) begin
		if (reset_in) begin
			pending_q <= 1'b0;
		end else if (state_q == RMC_ST_LOG_ADDR) begin
			pending_q <= 1'b1;
		end else if (irq_clear_in) begin
			pending_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_irq_cmd;
		take && irq_want;
	endsequence

	sequence s_two_logs;
		log_wr_out ##1 log_wr_out;
	endsequence

	// Command port held busy for the three logging cycles, then free again
	sequence s_busy_gap;
		!cmd_ready_out [*3] ##1 cmd_ready_out;
	endsequence

	a_undef_ignored: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(take && ignore) |=> resp_kind_out == RMC_RESP_NONE &&
		$stable(message_error_out))
		else $error("ignored command changed response or status");

	a_illegal_status: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(take && !ignore && illegal && !cmd_bcast_in) |=>
		message_error_out && resp_kind_out == RMC_RESP_STATUS)
		else $error("illegal command not answered with status and error");

	a_tx_data: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(take && !ignore && !illegal && !cmd_bcast_in && cmd_tr_in && has_data) |=>
		resp_kind_out == RMC_RESP_TX_DATA && resp_data_out == $past(mode_data_in))
		else $error("transmit mode data word missing");

	a_no_data_low: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(take && !cmd_code_in[`RMC_DATA_CODE_BIT]) |=>
		resp_kind_out inside {RMC_RESP_STATUS, RMC_RESP_NONE})
		else $error("data word on low mode code");

	a_rx_data: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(take && !ignore && !illegal && !cmd_tr_in && has_data) |=>
		resp_kind_out == RMC_RESP_RX_DATA)
		else $error("receive mode data word not expected");

	a_bus_ctrl_zero: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		take |-> ##[1:3] !bus_ctrl_accept_out)
		else $error("bus control acceptance bit set");

	a_log_then_irq: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		s_irq_cmd |=> s_two_logs ##1 message_interrupt_out)
		else $error("log words not written before interrupt");

	a_log_addr: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		s_irq_cmd |=> ##1 log_word_out == `RMC_DESC_BASE +
		(16'({$past(cmd_tr_in, 2), $past(cmd_code_in, 2)}) << `RMC_DESC_SHIFT))
		else $error("address log word wrong");

	a_bcast_tx_noirq: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(take && cmd_bcast_in && cmd_tr_in && has_data) |=> !log_wr_out)
		else $error("broadcast transmit high code interrupted");

	a_bcast_reject: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(take && !ignore && cmd_bcast_in && cmd_tr_in &&
		cmd_code_in == `RMC_MC_TX_STATUS) |=> message_error_out)
		else $error("broadcast transmit status accepted");

	a_store_place: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		take |=> store_in_descriptor_out == $past(simplified_mode_data_store_in))
		else $error("mode data store place wrong");

	a_legal_clear: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(take && !ignore && !illegal) |=> !message_error_out)
		else $error("legal command left message error set");

	a_busy_refuse: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		s_irq_cmd |=> s_busy_gap)
		else $error("command port not held busy while logging");

	a_pending_set: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(state_q == RMC_ST_LOG_ADDR) |=> message_interrupt_out)
		else $error("pending interrupt not raised after logging");

	a_vector_func: assert property (@(posedge ref_clk_in) disable iff (reset_in)
		(take && cmd_tr_in && cmd_code_in == `RMC_MC_TX_VECTOR) |=>
		resp_func_out == RMC_FN_TX_VECTOR)
		else $error("transmit vector command not decoded");

endmodule

/* File: bench/rmc_bc_model.sv */
// Bus controller model that issues mode commands to the handler
module rmc_bc_model
	import rmc_pkg::*;
(
	// Clock
	input wire logic ref_clk_in,
	// Handler answers
	input wire logic cmd_ready_in,
	input wire logic resp_valid_in,
	// Command fields
	output logic cmd_valid_out,
	output logic [4:0] cmd_code_out,
	output logic cmd_tr_out,
	output logic cmd_bcast_out,
	output logic [15:0] desc_ctrl_out,
	output logic [15:0] mode_data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] TX_WORD = 16'hA5C3;
	// Idle lines at time zero
	initial begin
		cmd_valid_out = 1'b0;
		cmd_code_out = 5'h00;
		cmd_tr_out = 1'b0;
		cmd_bcast_out = 1'b0;
		desc_ctrl_out = 16'h0000;
		mode_data_out = 16'h0000;
	end
	// Holds one command until taken, then reports whether the answer pulsed
	task automatic send(input logic [4:0] code, input logic tr, input logic bc,
		input logic [15:0] ctrl, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		@(posedge ref_clk_in);
		cmd_valid_out <= 1'b1;
		cmd_code_out <= code;
		cmd_tr_out <= tr;
		cmd_bcast_out <= bc;
		desc_ctrl_out <= ctrl;
		// Data word only with codes 16 to 31, junk otherwise
		mode_data_out <= code[4] ? TX_WORD : ~mode_data_out;
		do begin
			@(posedge ref_clk_in);
			n++;
		end while (cmd_ready_in !== 1'b1 && n < 20);
		if (cmd_ready_in === 1'b1) begin
			cmd_valid_out <= 1'b0;
			mode_data_out <= ~mode_data_out; // Released word no longer holds
			@(posedge ref_clk_in);
			ok = (resp_valid_in === 1'b1);
		end
	endtask
endmodule

/* File: bench/tb_rt_mode_command_handler.sv */
// Self-checking bench for the mode command handler
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end
module tb_rt_mode_command_handler
	import rmc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [4:0] code;
		logic tr, bc, uci;
		rmc_resp_t kind;
		rmc_func_t fn;
		logic merr;
	} rmc_row_t;
	logic ref_clk_in = 1'b0, reset_in = 1'b1, uci = 1'b0, smd = 1'b0, ien = 1'b0;
	logic tbl_wr = 1'b0, tbl_bit = 1'b0, irq_clr = 1'b0, ok;
	logic [6:0] tbl_addr = 7'h00;
	logic cmd_valid, cmd_tr, cmd_bcast, cmd_ready, resp_valid, merr, bca, store, log_wr, irq;
	logic [4:0] cmd_code;
	logic [15:0] desc_ctrl, mode_data, resp_data, log_word;
	rmc_resp_t resp_kind;
	rmc_func_t resp_func;
	int bad_count = 0, total_checks = 0;
	rmc_row_t rows [15] = '{
		'{5'h02, 1, 0, 0, RMC_RESP_STATUS, RMC_FN_TX_STATUS, 0},
		'{5'h00, 1, 0, 0, RMC_RESP_STATUS, RMC_FN_BUS_CTRL, 0},
		'{5'h08, 1, 0, 0, RMC_RESP_STATUS, RMC_FN_RESET_RT, 0},
		'{5'h10, 1, 0, 0, RMC_RESP_TX_DATA, RMC_FN_TX_VECTOR, 0},
		'{5'h11, 1, 0, 0, RMC_RESP_TX_DATA, RMC_FN_OTHER, 0},
		'{5'h19, 1, 0, 0, RMC_RESP_TX_DATA, RMC_FN_OTHER, 0},
		'{5'h12, 0, 0, 0, RMC_RESP_RX_DATA, RMC_FN_OTHER, 0},
		'{5'h05, 0, 0, 0, RMC_RESP_STATUS, RMC_FN_OTHER, 0},
		'{5'h01, 1, 1, 0, RMC_RESP_NONE, RMC_FN_OTHER, 0},
		'{5'h11, 0, 1, 0, RMC_RESP_RX_DATA, RMC_FN_OTHER, 0},
		'{5'h02, 1, 1, 0, RMC_RESP_NONE, RMC_FN_TX_STATUS, 1},
		'{5'h05, 0, 0, 1, RMC_RESP_NONE, RMC_FN_OTHER, 1},
		'{5'h15, 1, 0, 1, RMC_RESP_NONE, RMC_FN_OTHER, 1},
		'{5'h10, 0, 1, 0, RMC_RESP_NONE, RMC_FN_OTHER, 1},
		'{5'h03, 1, 0, 1, RMC_RESP_STATUS, RMC_FN_OTHER, 0}
	};
	// 200 MHz clock
	initial begin
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end
	// Bus controller on the command side
	rmc_bc_model bus_ctl (.ref_clk_in(ref_clk_in), .cmd_ready_in(cmd_ready),
		.resp_valid_in(resp_valid), .cmd_valid_out(cmd_valid), .cmd_code_out(cmd_code),
		.cmd_tr_out(cmd_tr), .cmd_bcast_out(cmd_bcast), .desc_ctrl_out(desc_ctrl),
		.mode_data_out(mode_data));
	rmc_mode_cmd dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.undefined_codes_invalid_in(uci), .simplified_mode_data_store_in(smd),
		.interrupt_enable_in(ien), .tbl_wr_in(tbl_wr), .tbl_addr_in(tbl_addr),
		.tbl_bit_in(tbl_bit), .cmd_valid_in(cmd_valid), .cmd_code_in(cmd_code),
		.cmd_tr_in(cmd_tr), .cmd_bcast_in(cmd_bcast), .desc_ctrl_in(desc_ctrl),
		.mode_data_in(mode_data), .cmd_ready_out(cmd_ready), .resp_valid_out(resp_valid),
		.resp_kind_out(resp_kind), .resp_data_out(resp_data), .resp_func_out(resp_func),
		.message_error_out(merr), .bus_ctrl_accept_out(bca),
		.store_in_descriptor_out(store), .log_wr_out(log_wr), .log_word_out(log_word),
		.irq_clear_in(irq_clr), .message_interrupt_out(irq));
	// Verdict and end of run
	task automatic complete_run();
		if (bad_count == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Sends one command; a missing answer ends the run
	task automatic issue(input logic [4:0] code, input logic tr, input logic bc,
		input logic [15:0] ctrl);
		bus_ctl.send(code, tr, bc, ctrl, ok);
		if (ok !== 1'b1) begin
			bad_count++;
			$display("[ERR] %0t no answer to command", $time);
			complete_run();
		end
	endtask
	// Writes one entry of the illegal table
	task automatic tbl_set(input logic [6:0] a, input logic b);
		@(posedge ref_clk_in);
		tbl_wr <= 1'b1;
		tbl_addr <= a;
		tbl_bit <= b;
		@(posedge ref_clk_in);
		tbl_wr <= 1'b0;
	endtask
	// Pulses the interrupt clear and checks the output drops
	task automatic clear_irq();
		irq_clr <= 1'b1;
		@(posedge ref_clk_in);
		irq_clr <= 1'b0;
		@(posedge ref_clk_in);
		`CHK(irq, 1'b0)
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge ref_clk_in);
		reset_in <= 1'b0;
		@(posedge ref_clk_in);
		`CHK(resp_kind, RMC_RESP_NONE)
		`CHK({cmd_ready, merr, irq, bca, log_wr}, 5'h10)
		// Table of ordinary cases
		foreach (rows[i]) begin
			uci <= rows[i].uci;
			smd <= i[0];
			issue(rows[i].code, rows[i].tr, rows[i].bc, 16'h0000);
			`CHK(resp_kind, rows[i].kind)
			`CHK(resp_data, (rows[i].kind == RMC_RESP_TX_DATA) ? 16'hA5C3 : 16'h0000)
			`CHK(merr, rows[i].merr)
			`CHK(bca, 1'b0)
			if (!rows[i].uci) `CHK(resp_func, rows[i].fn)
			if (!rows[i].uci) `CHK(store, i[0])
		end
		uci <= 1'b0;
		// Illegal transmit vector gives status only, then legal again
		tbl_set(7'h30, 1'b1);
		issue(5'h10, 1, 0, 16'h0000);
		`CHK({resp_kind, resp_data, merr}, {RMC_RESP_STATUS, 16'h0000, 1'b1})
		tbl_set(7'h30, 1'b0);
		issue(5'h10, 1, 0, 16'h0000);
		`CHK({resp_kind, merr}, {RMC_RESP_TX_DATA, 1'b0})
		// Mid-run reset clears a table bit set just before it
		tbl_set(7'h30, 1'b1);
		reset_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		reset_in <= 1'b0;
		@(posedge ref_clk_in);
		`CHK({resp_kind, cmd_ready, merr}, {RMC_RESP_NONE, 1'b1, 1'b0})
		issue(5'h10, 1, 0, 16'h0000);
		`CHK({resp_kind, resp_data, merr}, {RMC_RESP_TX_DATA, 16'hA5C3, 1'b0})
		// Interrupt on access logs two words before the interrupt rises
		ien <= 1'b1;
		issue(5'h03, 1, 0, 16'h8000);
		`CHK({log_wr, log_word[1:0], irq, cmd_ready}, 5'h14)
		@(posedge ref_clk_in);
		`CHK({log_wr, log_word}, {1'b1, 16'h028C})
		@(posedge ref_clk_in);
		`CHK({log_wr, irq}, 2'h1)
		clear_irq();
		// Broadcast transmit interrupt only below code 16
		issue(5'h10, 1, 1, 16'h4000);
		`CHK(log_wr, 1'b0)
		issue(5'h04, 1, 1, 16'h4000);
		`CHK({log_wr, log_word[1:0]}, 3'h7)
		repeat (2) @(posedge ref_clk_in);
		`CHK(irq, 1'b1)
		clear_irq();
		// Global enable off blocks the interrupt
		ien <= 1'b0;
		issue(5'h03, 1, 0, 16'h8000);
		repeat (2) @(posedge ref_clk_in);
		`CHK({log_wr, irq}, 2'h0)
		complete_run();
	end
endmodule
